// ===== src/rtcis_core.v
`timescale 1ns/10ps
`include "rtcis_regs.vh"
module rtcis_core (
    // Clock and reset
    input wire i_clk,
    input wire i_rst_n,
    // Serial link pins
    input wire i_scl,
    input wire i_sda,
    output wire o_sda,
    output wire o_sda_oe,
    // Settings seen by the compensation logic, and the bus busy flag
    output reg [4:0] o_turnover_temp_code,
    output reg [6:0] o_hot_curvature_bits,
    output reg o_temp_sense_enable,
    output reg o_busy
);
    // ****************************************
    // Line sampling
    // ****************************************
    wire scl_s;
    wire sda_s;
    reg scl_q;
    reg sda_q;

    rtcis_sync u_sync_scl (
        .i_clk(i_clk),
        .i_rst_n(i_rst_n),
        .i_pin(i_scl),
        .o_level(scl_s)
    );
    rtcis_sync u_sync_sda (
        .i_clk(i_clk),
        .i_rst_n(i_rst_n),
        .i_pin(i_sda),
        .o_level(sda_s)
    );

    always @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            scl_q <= 1'b1;
            sda_q <= 1'b1;
        end else begin
            scl_q <= scl_s;
            sda_q <= sda_s;
        end
    end

    wire scl_rise = scl_s & ~scl_q;
    wire scl_fall = ~scl_s & scl_q;
    wire start_det = scl_s & scl_q & sda_q & ~sda_s;
    wire stop_det = scl_s & scl_q & ~sda_q & sda_s;

    // ****************************************
    // Power-up hold-off
    // ****************************************
    reg [5:0] pwr_cnt_q;
    wire pwr_ready = (pwr_cnt_q == 6'h00);

    // Starts are ignored until the count runs out after reset
    always @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            pwr_cnt_q <= `RTCIS_PWRUP_CYC;
        end else if (!pwr_ready) begin
            pwr_cnt_q <= pwr_cnt_q - 6'h01;
        end
    end

    // ****************************************
    // Storage
    // ****************************************
    reg [7:0] user_mem [0:127];
    reg [7:0] reg_mem [0:47];

    function [7:0] next_ptr;
        input [7:0] ptr;
        input user_sp;
        begin
            if (user_sp) begin
                next_ptr = (ptr >= `RTCIS_USR_LAST) ? 8'h00 : ptr + 8'h01;
            end else begin
                next_ptr = (ptr >= `RTCIS_REG_LAST) ? 8'h00 : ptr + 8'h01;
            end
        end
    endfunction

    function [7:0] reg_read;
        input [7:0] a;
        input [4:0] turn;
        input [6:0] curv;
        input temp_sense_enable;
        input [7:0] memv;
        begin
            if (a == `RTCIS_REG_TURNOVER) begin
                reg_read = {3'h0, turn};
            end else if (a == `RTCIS_REG_HOT_CURV) begin
                reg_read = {1'b0, curv};
            end else if (a == `RTCIS_REG_TSE) begin
                reg_read = {temp_sense_enable, memv[6:0]};
            end else begin
                reg_read = memv;
            end
        end
    endfunction

    // ****************************************
    // Protocol engine
    // ****************************************
    localparam ST_IDLE = 3'd0;
    localparam ST_ADDR = 3'd1;
    localparam ST_ADDR_ACK = 3'd2;
    localparam ST_WORD = 3'd3;
    localparam ST_WORD_ACK = 3'd4;
    localparam ST_WDATA = 3'd5;
    localparam ST_RDATA = 3'd6;
    localparam ST_RACK = 3'd7;

    reg [2:0] state_q;
    reg [2:0] bit_cnt_q;
    reg [7:0] shift_q;
    reg [7:0] ptr_q;
    reg user_q;
    reg rw_q;
    reg word_done_q;
    reg sda_low_q;
    reg ack_hi_q;

    wire [7:0] rx_byte = {shift_q[6:0], sda_s};
    wire id_regs = (rx_byte[7:1] == `RTCIS_ID_REGS);
    wire id_user = (rx_byte[7:1] == `RTCIS_ID_USER);

    // ****************************************
    // Read data selection
    // ****************************************
    reg [7:0] rd_byte;

    // Settings are read back from the live outputs; bits 6:0 of register 0Dh come from memory
    always @* begin
        rd_byte = 8'h00;
        if (user_q) begin
            rd_byte = user_mem[ptr_q[6:0]];
        end else begin
            rd_byte = reg_read(ptr_q, o_turnover_temp_code, o_hot_curvature_bits,
                o_temp_sense_enable, reg_mem[ptr_q[5:0]]);
        end
    end

    // Open-drain: only ever pull low, never drive SCL
    assign o_sda = 1'b0;
    assign o_sda_oe = sda_low_q;

    always @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            state_q <= ST_IDLE;
            bit_cnt_q <= 3'd0;
            shift_q <= 8'h00;
            ptr_q <= `RTCIS_PTR_RST;
            user_q <= 1'b0;
            rw_q <= 1'b0;
            word_done_q <= 1'b0;
            sda_low_q <= 1'b0;
            ack_hi_q <= 1'b0;
            o_busy <= 1'b0;
        end else if (start_det && pwr_ready) begin
            // Repeated start keeps the pointer set by the dummy write
            state_q <= ST_ADDR;
            bit_cnt_q <= 3'd0;
            sda_low_q <= 1'b0;
            o_busy <= 1'b1;
        end else if (stop_det || state_q == ST_IDLE) begin
            state_q <= ST_IDLE;
            sda_low_q <= 1'b0;
            o_busy <= 1'b0;
        end else begin
            case (state_q)
                ST_ADDR, ST_WORD, ST_WDATA: begin
                    if (scl_rise) begin
                        shift_q <= rx_byte;
                        bit_cnt_q <= bit_cnt_q + 3'd1;
                        if (bit_cnt_q == 3'd7) begin
                            ack_hi_q <= 1'b0;
                            if (state_q == ST_ADDR) begin
                                if (id_regs || id_user) begin
                                    user_q <= id_user;
                                    rw_q <= rx_byte[0];
                                    state_q <= ST_ADDR_ACK;
                                end else begin
                                    state_q <= ST_IDLE;
                                end
                            end else begin
                                state_q <= ST_WORD_ACK;
                                word_done_q <= (state_q == ST_WORD);
                            end
                        end
                    end
                end
                ST_ADDR_ACK, ST_WORD_ACK: begin
                    // Pull low on fall after 8th bit; after 9th clock release, or on a read drive the first data bit
                    if (scl_fall && !ack_hi_q) begin
                        sda_low_q <= 1'b1;
                    end else if (scl_rise) begin
                        ack_hi_q <= 1'b1;
                    end else if (scl_fall && ack_hi_q) begin
                        bit_cnt_q <= 3'd0;
                        if (state_q == ST_ADDR_ACK && rw_q) begin
                            state_q <= ST_RDATA;
                            shift_q <= rd_byte;
                            sda_low_q <= ~rd_byte[7];
                        end else begin
                            sda_low_q <= 1'b0;
                            if (state_q == ST_ADDR_ACK) begin
                                state_q <= ST_WORD;
                            end else begin
                                state_q <= ST_WDATA;
                                if (word_done_q) begin
                                    ptr_q <= user_q ? {1'b0, shift_q[6:0]} : shift_q;
                                end else begin
                                    // Each stored byte moves the pointer on
                                    ptr_q <= next_ptr(ptr_q, user_q);
                                end
                                word_done_q <= 1'b0;
                            end
                        end
                    end
                end
                ST_RDATA: begin
                    if (scl_fall) begin
                        bit_cnt_q <= bit_cnt_q + 3'd1;
                        if (bit_cnt_q == 3'd7) begin
                            sda_low_q <= 1'b0;
                            ptr_q <= next_ptr(ptr_q, user_q);
                            state_q <= ST_RACK;
                        end else begin
                            shift_q <= {shift_q[6:0], 1'b0};
                            sda_low_q <= ~shift_q[6];
                        end
                    end
                end
                ST_RACK: begin
                    if (scl_rise) begin
                        if (sda_s) begin
                            state_q <= ST_IDLE;
                        end else begin
                            ack_hi_q <= 1'b1;
                        end
                    end else if (scl_fall && ack_hi_q) begin
                        ack_hi_q <= 1'b0;
                        bit_cnt_q <= 3'd0;
                        shift_q <= rd_byte;
                        sda_low_q <= ~rd_byte[7];
                        state_q <= ST_RDATA;
                    end
                end
                default: begin
                    state_q <= ST_IDLE;
                end
            endcase
        end
    end

    // ****************************************
    // Write port
    // ****************************************
    // Same cycle, same priority as the data-ack branch of the engine
    wire store_now = !(start_det && pwr_ready) && !stop_det &&
        (state_q == ST_WORD_ACK) && scl_fall && ack_hi_q && !word_done_q;
    reg wr_en_q;
    reg wr_user_q;
    reg [7:0] wr_addr_q;
    reg [7:0] wr_data_q;

    // Captured before the pointer moves on, applied one clock later
    always @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            wr_en_q <= 1'b0;
            wr_user_q <= 1'b0;
            wr_addr_q <= 8'h00;
            wr_data_q <= 8'h00;
        end else begin
            wr_en_q <= store_now;
            if (store_now) begin
                wr_user_q <= user_q;
                wr_addr_q <= ptr_q;
                wr_data_q <= shift_q;
            end
        end
    end

    // Memories carry no reset so they map onto plain RAM
    always @(posedge i_clk) begin
        if (wr_en_q && wr_user_q) begin
            user_mem[wr_addr_q[6:0]] <= wr_data_q;
        end
        // Writes above the last register are dropped
        if (wr_en_q && !wr_user_q && (wr_addr_q <= `RTCIS_REG_LAST)) begin
            reg_mem[wr_addr_q[5:0]] <= wr_data_q;
        end
    end

    // ****************************************
    // Compensation settings
    // ****************************************
    always @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_turnover_temp_code <= `RTCIS_TURNOVER_RST;
            o_hot_curvature_bits <= `RTCIS_HOT_CURV_RST;
            o_temp_sense_enable <= 1'b0;
        end else if (wr_en_q && !wr_user_q) begin
            if (wr_addr_q == `RTCIS_REG_TURNOVER) begin
                o_turnover_temp_code <= wr_data_q[4:0];
            end
            // Rewriting this while sensing runs is the master's risk
            if (wr_addr_q == `RTCIS_REG_HOT_CURV) begin
                o_hot_curvature_bits <= wr_data_q[6:0];
            end
            if (wr_addr_q == `RTCIS_REG_TSE) begin
                o_temp_sense_enable <= wr_data_q[`RTCIS_TSE_BIT];
            end
        end
    end
endmodule

// ===== src/rtcis_regs.vh
// Contract
// - Five-bit turnover code, signed half-degree steps
// - Turnover code resets to 00000b
// - Seven-bit hot curvature magnitude register
// - 128-byte user memory on own address
// - Slave only, never drives clock
// - Bytes shifted most significant bit first
// - Data changes only while clock low
// - Data pin input at power-up, start ignored
// - Nothing happens until start condition seen
// - Stop returns interface to standby
// - Transmitter releases, receiver acks ninth clock
// - Ack address, word address, write data
// - Seven-bit identifier match selects space
// - Direction bit one reads, zero writes
// - Word pointer resets to 00h
// - Write: three acked bytes then standby (code keeps acking further data bytes until stop)
// - Random read acks all three bytes
// - Read continues while master acks
// - Register pointer wraps 2Fh to 00h
// - Sensing runs only while enable set
`ifndef RTCIS_REGS_VH
`define RTCIS_REGS_VH
`define RTCIS_REG_TURNOVER 8'h2c
`define RTCIS_REG_HOT_CURV 8'h2d
`define RTCIS_REG_TSE 8'h0d
`define RTCIS_TSE_BIT 7
`define RTCIS_REG_LAST 8'h2f
`define RTCIS_USR_LAST 8'h7f
`define RTCIS_TURNOVER_RST 5'h00
`define RTCIS_HOT_CURV_RST 7'h00
`define RTCIS_PTR_RST 8'h00
// Both identifiers are arbitrary values
`define RTCIS_ID_REGS 7'h51
`define RTCIS_ID_USER 7'h52
// Power-up hold-off: 1000 ns at a 50 ns clock
`define RTCIS_PWRUP_CYC 6'h14
`endif

// ===== src/rtcis_sync.v
`timescale 1ns/10ps
module rtcis_sync (
    // Clock and reset
    input wire i_clk,
    input wire i_rst_n,
    // Pin level in, synchronised level out
    input wire i_pin,
    output reg o_level
);
    reg meta_q;

    // Reset to idle-high bus level so no false edge follows release
    always @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            meta_q <= 1'b1;
            o_level <= 1'b1;
        end else begin
            meta_q <= i_pin;
            o_level <= meta_q;
        end
    end
endmodule

// ===== bench/rtcis_core_chk.sv
`timescale 1ns/10ps
// ****
// Port checker
// ****
module rtcis_core_chk (
    // Clock, reset and pins
    input wire i_clk,
    input wire i_rst_n,
    input wire i_scl,
    input wire i_sda,
    input wire o_sda,
    input wire o_sda_oe,
    // Settings and status
    input wire [4:0] o_turnover_temp_code,
    input wire [6:0] o_hot_curvature_bits,
    input wire o_temp_sense_enable,
    input wire o_busy
);
    logic [5:0] pwr_q;
    // Cycles since reset release, saturating
    always @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) pwr_q <= 6'h00;
        else if (pwr_q != 6'h3f) pwr_q <= pwr_q + 6'h01;
    end
    default clocking @(posedge i_clk); endclocking
    default disable iff (!i_rst_n);
    property p_sda_low; o_sda_oe |-> !o_sda; endproperty
    a_sda_low: assert property (p_sda_low) else $error("data pin driven high");
    property p_idle_quiet; !o_busy |-> !o_sda_oe; endproperty
    a_idle_quiet: assert property (p_idle_quiet) else $error("pull while idle");
    property p_powerup; pwr_q < 6'h14 |-> !o_busy && !o_sda_oe; endproperty
    a_powerup: assert property (p_powerup) else $error("active in hold-off");
    property p_start; pwr_q > 6'h18 && i_scl && $past(i_scl) && $fell(i_sda) |-> ##[1:8] o_busy;
    endproperty
    a_start: assert property (p_start) else $error("start not taken");
    property p_stop; i_scl && $past(i_scl) && $rose(i_sda) |-> ##[1:8] !o_busy; endproperty
    a_stop: assert property (p_stop) else $error("stop not taken");
    property p_oe_hold; $rose(o_sda_oe) |-> ##1 o_sda_oe [*4]; endproperty
    a_oe_hold: assert property (p_oe_hold) else $error("pull too short");
    property p_oe_scl_low; $changed(o_sda_oe) |-> !$past(i_scl); endproperty
    a_oe_scl_low: assert property (p_oe_scl_low) else $error("data moved in clock high");
    property p_settings;
        $changed({o_turnover_temp_code, o_hot_curvature_bits, o_temp_sense_enable}) |-> $past(o_busy);
    endproperty
    a_settings: assert property (p_settings) else $error("setting moved off bus");
endmodule
bind rtcis_core rtcis_core_chk u_rtcis_core_chk (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_scl(i_scl),
    .i_sda(i_sda), .o_sda(o_sda), .o_sda_oe(o_sda_oe), .o_busy(o_busy),
    .o_turnover_temp_code(o_turnover_temp_code), .o_hot_curvature_bits(o_hot_curvature_bits),
    .o_temp_sense_enable(o_temp_sense_enable));

// ===== bench/rtcis_mst.sv
`timescale 1ns/10ps
// ****
// Bus master model
// ****
module rtcis_mst (
    // Clock and resolved data line
    input wire i_clk,
    input wire i_sda,
    // Master pins; the clock stands high between frames
    output reg o_scl = 1'b1,
    output reg o_sda_oe = 1'b0
);
    task tick;
        repeat (2) @(posedge i_clk);
        #1;
    endtask
    task start;
        o_sda_oe = 1'b0;
        tick;
        o_scl = 1'b1;
        tick;
        o_sda_oe = 1'b1;
        tick;
        o_scl = 1'b0;
        tick;
    endtask
    task stop;
        o_sda_oe = 1'b1;
        tick;
        o_scl = 1'b1;
        tick;
        o_sda_oe = 1'b0;
        tick;
    endtask
    // Data moves a quarter period into clock low, sampled mid high
    task bitx(input logic b, output logic r);
        o_sda_oe = ~b;
        tick;
        o_scl = 1'b1;
        tick;
        r = i_sda;
        tick;
        o_scl = 1'b0;
        tick;
    endtask
    task xfer(input logic [7:0] d, input logic ack_in, output logic [7:0] q, output logic ack);
        for (int i = 7; i >= 0; i--) bitx(d[i], q[i]);
        bitx(ack_in, ack);
    endtask
endmodule

// ===== bench/tb_rtcis_core.sv
`timescale 1ns/10ps
module tb_rtcis_core;
    typedef struct {logic [6:0] id; logic [7:0] a, d, rb; logic [12:0] o;} rtcis_row_t;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic [7:0] q;
    logic k;
    int n_fail = 0;
    int compares = 0;
    rtcis_row_t rows [6];
    wire scl, m_oe, oe, so, temp_sense_enable, busy;
    wire [4:0] turn;
    wire [6:0] hot;
    // Pull-up on the data line
    wire sda = ~(m_oe | (oe & ~so));
    rtcis_core u_rtcis_core (.i_clk(clk), .i_rst_n(rst_n), .i_scl(scl), .i_sda(sda), .o_sda(so),
        .o_sda_oe(oe), .o_turnover_temp_code(turn), .o_hot_curvature_bits(hot),
        .o_temp_sense_enable(temp_sense_enable), .o_busy(busy));
    rtcis_mst u_rtcis_mst (.i_clk(clk), .i_sda(sda), .o_scl(scl), .o_sda_oe(m_oe));
    task check(input logic [15:0] seen, input logic [15:0] exp, input string what);
        compares++;
        if (seen !== exp) begin
            n_fail++;
            $display("MISMATCH %0t %s seen %h want %h", $time, what, seen, exp);
        end
    endtask
    task wr(input logic [6:0] id, input logic [7:0] a, d0, d1, input int n);
        u_rtcis_mst.start();
        u_rtcis_mst.xfer({id, 1'b0}, 1'b1, q, k);
        check({15'h0, k}, 16'h0, "id ack");
        u_rtcis_mst.xfer(a, 1'b1, q, k);
        check({15'h0, k}, 16'h0, "word ack");
        if (n > 0) begin
            u_rtcis_mst.xfer(d0, 1'b1, q, k);
            check({15'h0, k}, 16'h0, "data ack");
        end
        if (n > 1) begin
            u_rtcis_mst.xfer(d1, 1'b1, q, k);
            check({15'h0, k}, 16'h0, "next data ack");
        end
        // A dummy write leaves the bus open for a repeated start
        if (n > 0) u_rtcis_mst.stop();
    endtask
    task rd(input logic [6:0] id, input logic [7:0] a, e0, e1, input int n);
        wr(id, a, 8'h00, 8'h00, 0);
        u_rtcis_mst.start();
        u_rtcis_mst.xfer({id, 1'b1}, 1'b1, q, k);
        check({15'h0, k}, 16'h0, "read id ack");
        u_rtcis_mst.xfer(8'hff, n == 1, q, k);
        check({8'h0, q}, {8'h0, e0}, "read");
        if (n > 1) u_rtcis_mst.xfer(8'hff, 1'b1, q, k);
        if (n > 1) check({8'h0, q}, {8'h0, e1}, "next read");
        u_rtcis_mst.stop();
    endtask
    task end_of_test;
        $display("Compares %0d mismatches %0d", compares, n_fail);
        if (n_fail == 0 && compares > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    initial begin
        forever #25 clk = ~clk;
    end
    initial begin
        #2000000;
        n_fail++;
        end_of_test();
    end
    initial begin
        rows[0] = '{7'h51, 8'h2c, 8'hff, 8'h1f, {5'h1f, 7'h00, 1'b0}};
        rows[1] = '{7'h51, 8'h2c, 8'h10, 8'h10, {5'h10, 7'h00, 1'b0}};
        rows[2] = '{7'h51, 8'h2d, 8'hff, 8'h7f, {5'h10, 7'h7f, 1'b0}};
        rows[3] = '{7'h51, 8'h0d, 8'h80, 8'h80, {5'h10, 7'h7f, 1'b1}};
        rows[4] = '{7'h51, 8'h0d, 8'h00, 8'h00, {5'h10, 7'h7f, 1'b0}};
        rows[5] = '{7'h52, 8'h7f, 8'ha5, 8'ha5, {5'h10, 7'h7f, 1'b0}};
        repeat (3) @(posedge clk);
        #1;
        rst_n = 1'b1;
        check({1'b0, turn, hot, temp_sense_enable, busy, oe}, 16'h0, "reset");
        // A start inside the power-up hold-off must be ignored
        u_rtcis_mst.start();
        u_rtcis_mst.xfer({7'h51, 1'b0}, 1'b1, q, k);
        check({15'h0, k}, 16'h1, "early start");
        u_rtcis_mst.stop();
        u_rtcis_mst.start();
        u_rtcis_mst.xfer({7'h51, 1'b1}, 1'b1, q, k);
        check({15'h0, k}, 16'h0, "current read id ack");
        u_rtcis_mst.xfer(8'hff, 1'b1, q, k);
        u_rtcis_mst.stop();
        wr(7'h51, 8'h00, 8'h3c, 8'h00, 1);
        rd(7'h51, 8'h00, 8'h3c, 8'h00, 1);
        $display("Reset tests done");
        foreach (rows[i]) begin
            wr(rows[i].id, rows[i].a, rows[i].d, 8'h00, 1);
            check({3'h0, turn, hot, temp_sense_enable}, {3'h0, rows[i].o}, "settings");
            rd(rows[i].id, rows[i].a, rows[i].rb, 8'h00, 1);
        end
        $display("Row tests done");
        wr(7'h51, 8'h2f, 8'hc3, 8'h00, 1);
        wr(7'h51, 8'h00, 8'h96, 8'h00, 1);
        rd(7'h51, 8'h2f, 8'hc3, 8'h96, 2);
        wr(7'h52, 8'h7f, 8'h5a, 8'h69, 2);
        rd(7'h52, 8'h7f, 8'h5a, 8'h69, 2);
        u_rtcis_mst.start();
        u_rtcis_mst.xfer({7'h33, 1'b0}, 1'b1, q, k);
        check({15'h0, k}, 16'h1, "foreign id");
        u_rtcis_mst.stop();
        $display("Edge tests done");
        rst_n = 1'b0;
        repeat (2) @(posedge clk);
        #1;
        rst_n = 1'b1;
        check({3'h0, turn, hot, temp_sense_enable}, 16'h0, "second reset");
        repeat (25) @(posedge clk);
        #1;
        // Memory survives reset, the pointer goes back to 00h
        u_rtcis_mst.start();
        u_rtcis_mst.xfer({7'h51, 1'b1}, 1'b1, q, k);
        u_rtcis_mst.xfer(8'hff, 1'b1, q, k);
        check({8'h0, q}, 16'h0096, "pointer after reset");
        u_rtcis_mst.stop();
        rd(7'h51, 8'h2c, 8'h00, 8'h00, 1);
        $display("Second reset test done");
        end_of_test();
    end
endmodule
